// ---- fsol_flash_security_option_loader.sv ----
`default_nettype none
// Summary of operation
// - Each reset copies stored protection and option bytes into working registers.
// - An eight-byte backdoor comparison key is held from reserved flash.
// - After reset the factory trim is loaded into the coarse and fine clock-source trim regs.
// - Backdoor key compare may unsecure only while key enable bit is 1.
// - Key entry accepted only from secure-memory code, never from debug commands.
// - With key disabled, security lifts only after mass erase then blank verify.
// - Stored lock field value 1:0 means unsecured after reset.
// - While secured, debug port and non-secure code are denied RAM access.
// - Factory info row is never readable or writable outside production test.
// - Flash is 512-byte pages, sixteen or eight pages by variant.
// - Secured debug may only blank check or mass erase; others flag access error.
// - Enabled block protection covers a 512-byte boundary up to the top address.
module fsol_flash_security_option_loader
    import fsol_pkg::*;
#(
    parameter int PAGE_COUNT = 16
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // register access from the cpu or debug controller
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        accessFromDebug,
    input  wire logic        accessFromSecureCode,
    input  wire logic        productionTest,
    output logic      [7:0]  regRdData,
    // nonvolatile array read port used by the loader
    output logic             nvRead,
    output logic      [15:0] nvAddr,
    input  wire logic [7:0]  nvData,
    input  wire logic [7:0]  factoryTrim,
    input  wire logic        factoryFineTrim,
    // flash command engine hand-off
    output logic             cmdLaunch,
    input  wire logic        cmdComplete,
    input  wire logic        blankResult,
    // clock-source trim outputs
    output logic      [7:0]  clockSourceAdjust,
    output logic             clockSourceFineAdjust,
    // security status
    output logic             cpuHoldInReset,
    output logic             secured,
    output logic             ramAccessAllow,
    output logic             infoRowAccessAllow,
    output logic             protectHit
);
    import fsol_pkg::*;

    fsol_state_t         state_q;
    logic [7:0]          protect_q;
    logic [7:0]          option_q;
    logic [63:0]         key_q;
    logic [2:0]          keyIdx_q;
    logic                unlocked_q;
    logic                erased_q;
    logic [7:0]          clkDiv_q;
    logic [7:0]          config_q;
    logic [7:0]          status_q;
    logic [7:0]          command_q;
    logic [7:0]          keyShadow_q [KEY_BYTES];
    logic [2:0]          keyWrIdx_q;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic cmd_legal(input logic [7:0] c);
        return (c == CMD_BLANK_CHECK) || (c == CMD_BYTE_PROG) || (c == CMD_BURST_PROG)
            || (c == CMD_PAGE_ERASE) || (c == CMD_MASS_ERASE);
    endfunction : cmd_legal

    function automatic logic in_protected(input logic [15:0] a, input logic [7:0] p);
        logic [15:0] base;
        base = {p[7:1], 9'h000};
        return (p[PROT_DISABLE] == 1'b0) && (a >= base) && (a <= FLASH_TOP);
    endfunction : in_protected

    // ------------------------------------------------------------
    // reset load sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q  <= FSOL_IDLE;
            keyIdx_q <= 3'h0;
        end else begin
            unique case (state_q)
                FSOL_IDLE:    state_q <= FSOL_PROTECT;
                FSOL_PROTECT: state_q <= FSOL_OPTION;
                FSOL_OPTION:  state_q <= FSOL_TRIM;
                FSOL_TRIM:    state_q <= FSOL_KEY;
                FSOL_KEY: begin
                    keyIdx_q <= keyIdx_q + 3'h1;
                    if (keyIdx_q == 3'h7) begin
                        state_q <= FSOL_READY;
                    end
                end
                FSOL_READY:   state_q <= FSOL_READY;
                default:      state_q <= FSOL_IDLE;
            endcase
        end
    end

    // the protect, option and key states address the cell that each captures in that same cycle
    always_comb begin
        nvRead = (state_q != FSOL_READY);
        unique case (state_q)
            FSOL_IDLE:    nvAddr = NV_PROTECT;
            FSOL_PROTECT: nvAddr = NV_PROTECT;
            FSOL_OPTION:  nvAddr = NV_OPTION;
            FSOL_TRIM:    nvAddr = NV_KEY_FIRST;
            FSOL_KEY:     nvAddr = NV_KEY_FIRST + 16'(keyIdx_q);
            default:      nvAddr = NV_KEY_LAST;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            protect_q <= 8'hFF;
            option_q  <= ZERO_BYTE;
        end else if (state_q == FSOL_PROTECT) begin
            protect_q <= nvData;
        end else if (state_q == FSOL_OPTION) begin
            option_q  <= nvData;
        end else if (state_q == FSOL_READY && regWrite && regAddr == REG_PROTECT_COPY
                     && !secured) begin
            // protection may only be tightened by software
            protect_q <= protect_q & regWrData;
        end
    end

    // key shifted in over the eight key slots, lowest address ends on top
    always_ff @(posedge clock) begin
        if (rst) begin
            key_q <= 64'h0;
        end else if (state_q == FSOL_KEY) begin
            key_q <= {key_q[55:0], nvData};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clockSourceAdjust     <= 8'h80;
            clockSourceFineAdjust <= 1'b0;
        end else if (state_q == FSOL_TRIM) begin
            clockSourceAdjust     <= factoryTrim;
            clockSourceFineAdjust <= factoryFineTrim;
        end
    end

    assign cpuHoldInReset = (state_q != FSOL_READY);

    // ------------------------------------------------------------
    // security state
    // ------------------------------------------------------------
    logic keyWrite;
    logic keyFull;
    logic keyMatch;
    logic [63:0] keyEntered;
    always_comb begin
        keyEntered = 64'h0;
        for (int i = 0; i < KEY_BYTES; i++) begin
            keyEntered[63 - 8 * i -: 8] = keyShadow_q[i];
        end
        keyWrite = regWrite && regAddr >= NV_KEY_FIRST && regAddr <= NV_KEY_LAST
                   && config_q[CFG_KEY_ACCESS] && state_q == FSOL_READY
                   && accessFromSecureCode && !accessFromDebug;
        keyFull  = keyWrite && keyWrIdx_q == 3'h7;
        keyMatch = option_q[OPT_KEY_ENABLE] && keyFull
                   && ({keyEntered[63:8], regWrData} == key_q);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            keyWrIdx_q    <= 3'h0;
            for (int i = 0; i < KEY_BYTES; i++) keyShadow_q[i] <= ZERO_BYTE;
        end else if (keyWrite) begin
            keyShadow_q[keyWrIdx_q] <= regWrData;
            keyWrIdx_q              <= keyWrIdx_q + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            unlocked_q <= 1'b0;
        end else if (keyMatch) begin
            unlocked_q <= 1'b1;
        end
    end

    // mass erase then verified blank releases security
    always_ff @(posedge clock) begin
        if (rst) begin
            erased_q <= 1'b0;
        end else if (cmdComplete && command_q == CMD_MASS_ERASE) begin
            erased_q <= 1'b1;
        end
    end

    logic blankVerified_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            blankVerified_q <= 1'b0;
        end else if (cmdComplete && command_q == CMD_BLANK_CHECK && erased_q && blankResult) begin
            blankVerified_q <= 1'b1;
        end
    end

    assign secured = (state_q != FSOL_READY)
                     || ((option_q[1:0] != LOCK_UNSECURED)
                         && !unlocked_q && !blankVerified_q);
    assign ramAccessAllow     = !secured || (accessFromSecureCode && !accessFromDebug);
    assign infoRowAccessAllow = productionTest;
    assign protectHit = in_protected(regAddr, protect_q)
                        && (regAddr >= (FLASH_TOP - 16'(PAGE_COUNT * PAGE_BYTES) + 16'h1));

    // ------------------------------------------------------------
    // flash control registers
    // ------------------------------------------------------------
    logic cmdWrite;
    logic cmdRefused;
    assign cmdWrite   = regWrite && regAddr == REG_COMMAND && state_q == FSOL_READY;
    assign cmdRefused = !cmd_legal(regWrData) || (secured && accessFromDebug
                        && regWrData != CMD_BLANK_CHECK && regWrData != CMD_MASS_ERASE);

    always_ff @(posedge clock) begin
        if (rst) begin
            clkDiv_q  <= ZERO_BYTE;
            config_q  <= ZERO_BYTE;
            command_q <= ZERO_BYTE;
        end else begin
            if (regWrite && regAddr == REG_CLOCK_DIV && !clkDiv_q[7]
                && !status_q[STAT_ACC_ERR]) begin
                clkDiv_q <= {1'b1, regWrData[6:0]};
            end
            if (regWrite && regAddr == REG_CONFIG) begin
                config_q <= regWrData & 8'h20;
            end
            if (cmdWrite && !cmdRefused) begin
                command_q <= regWrData;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            status_q <= STATUS_RESET;
        end else begin
            if (regWrite && regAddr == REG_STATUS && regWrData[STAT_ACC_ERR]) begin
                status_q[STAT_ACC_ERR] <= 1'b0;
            end
            if (cmdWrite && cmdRefused) begin
                status_q[STAT_ACC_ERR] <= 1'b1;
            end
            if (cmdLaunch) begin
                status_q[STAT_CMD_EMPTY] <= 1'b0;
                status_q[STAT_CMD_DONE]  <= 1'b0;
            end else if (cmdComplete) begin
                status_q[STAT_CMD_EMPTY] <= 1'b1;
                status_q[STAT_CMD_DONE]  <= 1'b1;
                status_q[STAT_BLANK]     <= blankResult;
            end
        end
    end

    assign cmdLaunch = regWrite && regAddr == REG_STATUS && regWrData[STAT_CMD_EMPTY]
                       && status_q[STAT_CMD_EMPTY] && !status_q[STAT_ACC_ERR]
                       && cmd_legal(command_q);

    always_ff @(posedge clock) begin
        if (rst) begin
            regRdData <= ZERO_BYTE;
        end else if (regRead) begin
            unique case (regAddr)
                REG_CLOCK_DIV:    regRdData <= clkDiv_q;
                REG_OPTION_COPY:  regRdData <= {option_q[7:6], 4'h0, option_q[1:0]};
                REG_CONFIG:       regRdData <= config_q;
                REG_PROTECT_COPY: regRdData <= protect_q;
                REG_STATUS:       regRdData <= status_q;
                REG_COMMAND:      regRdData <= command_q;
                default:          regRdData <= ZERO_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_LOAD_DONE: assert property (@(posedge clock) $fell(rst) |-> ##12 !cpuHoldInReset)
        else $error("load not finished in time");
    AST_COPY_OPT: assert property (@(posedge clock) disable iff (rst)
        state_q == FSOL_OPTION |=> option_q == $past(nvData))
        else $error("option byte not copied");
    AST_UNSEC: assert property (@(posedge clock) disable iff (rst)
        (state_q == FSOL_READY && option_q[1:0] == LOCK_UNSECURED) |-> !secured)
        else $error("unsecured code seen as secured");
    AST_KEY_ENABLE_BIT: assert property (@(posedge clock) disable iff (rst)
        (!option_q[OPT_KEY_ENABLE] && !unlocked_q) |=> !unlocked_q)
        else $error("key unlocked while disabled");
    AST_DBGKEY: assert property (@(posedge clock) disable iff (rst)
        accessFromDebug |-> !keyWrite)
        else $error("key entry via debug");
    AST_RAM: assert property (@(posedge clock) disable iff (rst)
        (secured && accessFromDebug) |-> !ramAccessAllow)
        else $error("ram open to debug while secured");
    AST_DBGCMD: assert property (@(posedge clock) disable iff (rst)
        (cmdWrite && secured && accessFromDebug && regWrData != CMD_BLANK_CHECK
         && regWrData != CMD_MASS_ERASE) |=> status_q[STAT_ACC_ERR])
        else $error("secured debug command not refused");
    AST_TRIM: assert property (@(posedge clock) disable iff (rst)
        state_q == FSOL_TRIM |=> clockSourceAdjust == $past(factoryTrim))
        else $error("trim not loaded");
    AST_IFR: assert property (@(posedge clock) disable iff (rst)
        !productionTest |-> !infoRowAccessAllow)
        else $error("info row open");
endmodule : fsol_flash_security_option_loader
`default_nettype wire

// ---- fsol_pkg.sv ----
`default_nettype none
package fsol_pkg;
    // ------------------------------------------------------------
    // register offsets (high page)
    // ------------------------------------------------------------
    localparam logic [15:0] REG_CLOCK_DIV    = 16'h1820;
    localparam logic [15:0] REG_OPTION_COPY  = 16'h1821;
    localparam logic [15:0] REG_CONFIG       = 16'h1823;
    localparam logic [15:0] REG_PROTECT_COPY = 16'h1824;
    localparam logic [15:0] REG_STATUS       = 16'h1825;
    localparam logic [15:0] REG_COMMAND      = 16'h1826;
    // ------------------------------------------------------------
    // reserved flash locations
    // ------------------------------------------------------------
    localparam logic [15:0] NV_FINE_ADJ      = 16'hFFAE;
    localparam logic [15:0] NV_COARSE_ADJ    = 16'hFFAF;
    localparam logic [15:0] NV_KEY_FIRST     = 16'hFFB0;
    localparam logic [15:0] NV_KEY_LAST      = 16'hFFB7;
    localparam logic [15:0] NV_PROTECT       = 16'hFFBD;
    localparam logic [15:0] NV_OPTION        = 16'hFFBF;
    localparam logic [15:0] FLASH_TOP        = 16'hFFFF;
    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int          OPT_KEY_ENABLE   = 7;
    localparam int          CFG_KEY_ACCESS   = 5;
    localparam int          STAT_CMD_EMPTY   = 7;
    localparam int          STAT_CMD_DONE    = 6;
    localparam int          STAT_PROT_VIOL   = 5;
    localparam int          STAT_ACC_ERR     = 4;
    localparam int          STAT_BLANK       = 2;
    localparam int          PROT_DISABLE     = 0;
    localparam logic [1:0]  LOCK_UNSECURED   = 2'h2;
    localparam logic [7:0]  CMD_BLANK_CHECK  = 8'h05;
    localparam logic [7:0]  CMD_BYTE_PROG    = 8'h20;
    localparam logic [7:0]  CMD_BURST_PROG   = 8'h25;
    localparam logic [7:0]  CMD_PAGE_ERASE   = 8'h40;
    localparam logic [7:0]  CMD_MASS_ERASE   = 8'h41;
    localparam int          PAGE_BYTES       = 512;
    localparam int          PAGE_SHIFT       = 9;
    localparam int          KEY_BYTES        = 8;
    localparam logic [7:0]  STATUS_RESET     = 8'hC0;
    localparam logic [7:0]  ZERO_BYTE        = 8'h00;
    // ------------------------------------------------------------
    // load sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSOL_IDLE    = 3'b000,
        FSOL_PROTECT = 3'b001,
        FSOL_OPTION  = 3'b011,
        FSOL_TRIM    = 3'b010,
        FSOL_KEY     = 3'b110,
        FSOL_READY   = 3'b111
    } fsol_state_t;
endpackage : fsol_pkg
`default_nettype wire

// ---- fsol_flash_model.sv ----
`default_nettype none
module fsol_flash_model #(
    parameter logic [63:0] KEY          = 64'h0123456789ABCDEF,
    parameter logic [7:0]  TRIM_VAL     = 8'h5A,
    parameter int          ENGINE_TICKS = 6
) (
    // clock
    input  wire logic        clock,
    // array contents chosen by the bench
    input  wire logic [7:0]  protByte,
    input  wire logic [7:0]  optByte,
    input  wire logic        arrayBlank,
    // loader read port
    input  wire logic        nvRead,
    input  wire logic [15:0] nvAddr,
    output logic      [7:0]  nvData,
    output logic      [7:0]  factoryTrim,
    output logic             factoryFineTrim,
    // command engine
    input  wire logic        cmdLaunch,
    output logic             cmdComplete,
    output logic             blankResult
);
    timeunit 1ns;
    timeprecision 1ns;
    import fsol_pkg::*;
    logic [7:0] lastData = 8'h00;
    logic [7:0] cellData;
    int         busyCount = 0;
    // ------------------------------------------------------------
    // reserved flash cells
    // ------------------------------------------------------------
    always_comb begin
        cellData = 8'hFF;
        if (nvAddr == NV_PROTECT) cellData = protByte;
        if (nvAddr == NV_OPTION) cellData = optByte;
        if (nvAddr >= NV_KEY_FIRST && nvAddr <= NV_KEY_LAST) begin
            cellData = KEY[{nvAddr[2:0], 3'h0} +: 8];
        end
        // stored adjust bytes are plain cells, nothing pushes them out
        if (nvAddr == NV_FINE_ADJ) cellData = 8'h01;
        if (nvAddr == NV_COARSE_ADJ) cellData = 8'h3C;
    end
    // released port shows the inverse of the last value
    assign nvData          = nvRead ? cellData : ~lastData;
    assign factoryTrim     = TRIM_VAL;
    assign factoryFineTrim = 1'b1;
    always_ff @(posedge clock) begin
        if (nvRead) lastData <= cellData;
    end
    // ------------------------------------------------------------
    // command engine: fixed latency, one-cycle completion pulse
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (cmdLaunch) busyCount <= ENGINE_TICKS;
        else if (busyCount > 0) busyCount <= busyCount - 1;
    end
    assign cmdComplete = (busyCount == 1);
    assign blankResult = arrayBlank;
endmodule : fsol_flash_model
`default_nettype wire

// ---- fsol_flash_security_option_loader_bench.sv ----
`default_nettype none
module fsol_flash_security_option_loader_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import fsol_pkg::*;
    localparam logic [63:0] KEY      = 64'h0123456789ABCDEF;
    localparam logic [7:0]  TRIM_VAL = 8'h5A;
    logic clock, rst, regWrite, regRead, accessFromDebug, accessFromSecureCode;
    logic productionTest, nvRead, factoryFineTrim, cmdLaunch, cmdComplete, blankResult;
    logic clockSourceFineAdjust, cpuHoldInReset, secured, ramAccessAllow;
    logic infoRowAccessAllow, protectHit, arrayBlank;
    logic [15:0] regAddr, nvAddr;
    logic [7:0]  regWrData, regRdData, nvData, factoryTrim, clockSourceAdjust;
    logic [7:0]  protByte, optByte, d;
    int          n_errors = 0;
    int          cmp_count = 0;

    fsol_flash_security_option_loader #(.PAGE_COUNT(16)) fsol_flash_security_option_loader_inst (
        .clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .accessFromDebug(accessFromDebug),
        .accessFromSecureCode(accessFromSecureCode), .productionTest(productionTest),
        .regRdData(regRdData), .nvRead(nvRead), .nvAddr(nvAddr), .nvData(nvData),
        .factoryTrim(factoryTrim), .factoryFineTrim(factoryFineTrim),
        .cmdLaunch(cmdLaunch), .cmdComplete(cmdComplete), .blankResult(blankResult),
        .clockSourceAdjust(clockSourceAdjust), .clockSourceFineAdjust(clockSourceFineAdjust),
        .cpuHoldInReset(cpuHoldInReset), .secured(secured), .ramAccessAllow(ramAccessAllow),
        .infoRowAccessAllow(infoRowAccessAllow), .protectHit(protectHit));

    fsol_flash_model #(.KEY(KEY), .TRIM_VAL(TRIM_VAL), .ENGINE_TICKS(6)) fsol_flash_model_inst (
        .clock(clock), .protByte(protByte), .optByte(optByte), .arrayBlank(arrayBlank),
        .nvRead(nvRead), .nvAddr(nvAddr), .nvData(nvData), .factoryTrim(factoryTrim),
        .factoryFineTrim(factoryFineTrim), .cmdLaunch(cmdLaunch),
        .cmdComplete(cmdComplete), .blankResult(blankResult));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock);
        regWrite  = 1'b1;
        regAddr   = addr;
        regWrData = data;
        @(negedge clock);
        regWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] addr, output logic [7:0] data);
        @(negedge clock);
        regRead = 1'b1;
        regAddr = addr;
        @(negedge clock);
        regRead = 1'b0;
        data    = regRdData;
    endtask : rd
    task automatic src(input logic dbg, input logic sec);
        @(negedge clock);
        accessFromDebug      = dbg;
        accessFromSecureCode = sec;
        #1;
    endtask : src
    // command write, then launch write; launch pulse checked when asked
    task automatic launch(input logic [7:0] cmd, input logic chk);
        wr(REG_COMMAND, cmd);
        @(negedge clock);
        regWrite  = 1'b1;
        regAddr   = REG_STATUS;
        regWrData = 8'h80;
        #1;
        if (chk) check(cmdLaunch, 1'b1);
        @(negedge clock);
        regWrite = 1'b0;
    endtask : launch
    task automatic wait_done();
        for (int i = 0; i < 40; i++) begin
            rd(REG_STATUS, d);
            if (d[STAT_CMD_DONE] === 1'b1) break;
        end
        check(d[STAT_CMD_DONE], 1'b1);
    endtask : wait_done
    task automatic enter_key(input logic [7:0] flip);
        wr(REG_CONFIG, 8'h20);
        for (int i = 0; i < KEY_BYTES; i++) begin
            wr(NV_KEY_FIRST + 16'(i), KEY[8*i +: 8] ^ (i == 7 ? flip : 8'h00));
        end
    endtask : enter_key
    task automatic restart(input logic [7:0] opt, input logic [7:0] prot);
        int i;
        @(negedge clock);
        rst      = 1'b1;
        optByte  = opt;
        protByte = prot;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        for (i = 0; i < 12 && cpuHoldInReset !== 1'b0; i++) @(negedge clock);
        check(cpuHoldInReset, 1'b0);
    endtask : restart
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {regWrite, regRead, accessFromDebug, accessFromSecureCode, productionTest} = 5'h00;
        {regAddr, regWrData, arrayBlank, rst} = {16'h0000, 8'h00, 1'b0, 1'b1};
        {optByte, protByte} = {8'h83, 8'hFF};
        restart(8'h83, 8'hFF);
        rd(REG_OPTION_COPY, d);
        check(d, 8'h83);
        rd(REG_PROTECT_COPY, d);
        check(d, 8'hFF);
        check(clockSourceAdjust, TRIM_VAL);
        check(clockSourceFineAdjust, 1'b1);
        check(secured, 1'b1);
        src(1'b1, 1'b0);
        check(ramAccessAllow, 1'b0);
        src(1'b0, 1'b0);
        check(ramAccessAllow, 1'b0);
        src(1'b0, 1'b1);
        check(ramAccessAllow, 1'b1);
        @(negedge clock) productionTest = 1'b1;
        #1 check(infoRowAccessAllow, 1'b1);
        @(negedge clock) productionTest = 1'b0;
        #1 check(infoRowAccessAllow, 1'b0);
        src(1'b1, 1'b0);
        enter_key(8'h00);
        check(secured, 1'b1);
        src(1'b0, 1'b1);
        enter_key(8'h01);
        check(secured, 1'b1);
        enter_key(8'h00);
        check(secured, 1'b0);
        src(1'b1, 1'b0);
        check(ramAccessAllow, 1'b1);
        restart(8'h83, 8'hFF);
        check(secured, 1'b1);
        launch(CMD_BYTE_PROG, 1'b0);
        rd(REG_STATUS, d);
        check(d[STAT_ACC_ERR], 1'b1);
        restart(8'h83, 8'hFF);
        launch(CMD_BLANK_CHECK, 1'b1);
        rd(REG_STATUS, d);
        check(d[STAT_ACC_ERR], 1'b0);
        restart(8'h03, 8'hFF);
        src(1'b0, 1'b1);
        enter_key(8'h00);
        check(secured, 1'b1);
        src(1'b1, 1'b0);
        arrayBlank = 1'b1;
        launch(CMD_MASS_ERASE, 1'b1);
        wait_done();
        check(secured, 1'b1);
        launch(CMD_BLANK_CHECK, 1'b1);
        wait_done();
        check(secured, 1'b0);
        src(1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            restart({6'h00, 2'(k)}, 8'hFF);
            check(secured, 2'(k) != LOCK_UNSECURED);
        end
        restart(8'h02, 8'hFF);
        wr(REG_PROTECT_COPY, 8'hF0);
        @(negedge clock) regAddr = 16'hF200;
        #1 check(protectHit, 1'b1);
        @(negedge clock) regAddr = 16'hE200;
        #1 check(protectHit, 1'b0);
        wr(REG_PROTECT_COPY, 8'hFF);
        rd(REG_PROTECT_COPY, d);
        check(d, 8'hF0);
        wr(REG_PROTECT_COPY, 8'h00);
        @(negedge clock) regAddr = 16'hDFFF;
        #1 check(protectHit, 1'b0);
        @(negedge clock) regAddr = 16'hE000;
        #1 check(protectHit, 1'b1);
        finish_test();
    end
    initial begin
        #(4000 * 100);
        n_errors++;
        finish_test();
    end
endmodule : fsol_flash_security_option_loader_bench
`default_nettype wire
